// *** sfs_supervisor.sv ***
// Contract
// - lockout threshold 2.85-16V, inhibit below it
// - open strap selects 4.5V threshold
// - tri-level strap: low 3V, high 10.8V
// - strap resistor lookup, 17.8k to 100k
// - host threshold in range replaces strapped one
// - delayed undervoltage response latches off until restart
// - undervoltage: continue, or shutdown with retries
// - default undervoltage: shutdown, auto re-enable
// - overvoltage above target plus 15 percent
// - overvoltage drops power-good first; code drops it on the same edge as the high-side driver
// - overvoltage shutdown with selectable retries
// - crowbar: high-side off, low-side on
// - default overvoltage: shutdown, auto re-enable
// - external clock allows only shutdown response
// - sample output before ramp for pre-bias
// - below target: ramp from pre-bias level
// - ramp time fixed whatever the start
// - above target: reference at pre-bias, drivers on
// - above target: power-good, then ramp down
// - pre-bias over limit: overvoltage fault, no start
`default_nettype none
`include "sfs_consts.svh"
module sfs_supervisor #(
    parameter int unsigned CNT_W          = 21,
    parameter int unsigned ON_DELAY_CYCLES = `SFS_ON_DELAY_US * `SFS_CLK_MHZ,
    parameter int unsigned RAMP_CYCLES    = `SFS_RAMP_MS * `SFS_US_PER_MS * `SFS_CLK_MHZ,
    parameter int unsigned UV_DELAY_CYCLES = `SFS_UV_DELAY_US * `SFS_CLK_MHZ
) (
    input  wire logic                       CLK,
    input  wire logic                       RESET_N,
    input  wire logic                       ENABLE,
    input  wire logic                       RESTART,
    input  wire sfs_pkg::sfs_strap_t        STRAP_LEVEL,
    input  wire logic [`SFS_RES_IDX_W-1:0]  STRAP_RES_IDX,
    input  wire logic [`SFS_MV_W-1:0]       HOST_THR_MV,
    input  wire logic                       HOST_THR_VALID,
    input  wire logic [`SFS_MV_W-1:0]       VIN_MV,
    input  wire logic [`SFS_MV_W-1:0]       VSENSE_MV,
    input  wire logic [`SFS_MV_W-1:0]       TARGET_MV,
    input  wire logic [`SFS_PCT_W-1:0]      OV_PCT,
    input  wire sfs_pkg::sfs_uv_resp_t      UV_RESP,
    input  wire logic [`SFS_RETRY_W-1:0]    UV_RETRIES,
    input  wire sfs_pkg::sfs_ov_resp_t      OV_RESP,
    input  wire logic [`SFS_RETRY_W-1:0]    OV_RETRIES,
    input  wire logic                       EXT_CLK_MODE,
    input  wire logic                       FLAG_CLR,
    output logic                            POWER_GOOD,
    output logic                            HS_EN,
    output logic                            LS_EN,
    output logic [`SFS_MV_W-1:0]            REF_MV,
    output logic [`SFS_MV_W-1:0]            LOCKOUT_THR_MV,
    output logic                            UV_FLAG,
    output logic                            OV_FLAG
);
    import sfs_pkg::*;

    localparam int unsigned PW = `SFS_MV_W + CNT_W;
    localparam logic [CNT_W-1:0] DLY_LAST  = CNT_W'(ON_DELAY_CYCLES - 1);
    localparam logic [CNT_W-1:0] RAMP_LAST = CNT_W'(RAMP_CYCLES - 1);
    localparam logic [CNT_W-1:0] UV_LAST   = CNT_W'(UV_DELAY_CYCLES - 1);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    sfs_state_t                 state_ff;
    sfs_state_t                 nxt_state;
    logic                       en_s1_ff;
    logic                       en_s2_ff;
    logic [CNT_W-1:0]           cnt_ff;
    logic [CNT_W-1:0]           nxt_cnt;
    logic [CNT_W-1:0]           uv_dly_ff;
    logic [`SFS_RETRY_W-1:0]    uv_tries_ff;
    logic [`SFS_RETRY_W-1:0]    ov_tries_ff;
    logic                       cause_ov_ff;
    logic [`SFS_MV_W-1:0]       pb_ff;
    logic                       above_ff;
    logic [`SFS_MV_W-1:0]       strap_thr;
    logic [`SFS_MV_W-1:0]       thr_eff;
    logic                       host_ok;
    logic                       uv;
    logic                       ov;
    logic [`SFS_PCT_W:0]        ov_pct_eff;
    logic                       active;
    logic                       counting;
    logic                       dly_done;
    logic                       ramp_done;
    logic                       uv_trip;
    logic                       uv_give_up;
    logic                       uv_retry_ok;
    logic                       ov_retry_ok;
    logic                       retry_ok;
    logic                       cause_clear;
    logic                       run_fault;
    logic                       sample_now;
    sfs_state_t                 ov_dest;
    logic [`SFS_MV_W-1:0]       nxt_pb;
    logic                       nxt_above;
    logic [`SFS_MV_W-1:0]       ramp_diff;
    logic [PW-1:0]              ramp_prod;
    logic [`SFS_MV_W-1:0]       ramp_frac;
    logic [`SFS_MV_W-1:0]       nxt_ref;
    logic                       nxt_pg;
    logic                       nxt_hs;
    logic                       nxt_ls;
    logic                       retry_step;

    // strap capture and table lookup
    sfs_strap_decode u_strap (
        .clk         (CLK),
        .reset_n     (RESET_N),
        .strap_pin   (STRAP_LEVEL),
        .res_idx_pin (STRAP_RES_IDX),
        .thr_mv      (strap_thr)
    );

    // enable pin synchroniser
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            en_s1_ff <= 1'b0;
            en_s2_ff <= 1'b0;
        end else begin
            en_s1_ff <= ENABLE;
            en_s2_ff <= en_s1_ff;
        end
    end

    // threshold choice and fault comparators
    assign host_ok    = HOST_THR_VALID && (HOST_THR_MV >= `SFS_THR_MIN_MV)
                        && (HOST_THR_MV <= `SFS_THR_MAX_MV);
    assign thr_eff    = host_ok ? HOST_THR_MV : strap_thr;
    assign uv         = VIN_MV < thr_eff;
    assign ov_pct_eff = (OV_PCT == '0) ? {1'b0, `SFS_OV_PCT_DEF} : {1'b0, OV_PCT};
    assign ov = ({8'h00, VSENSE_MV} * {16'h0000, `SFS_PCT_FULL})
                > ({8'h00, TARGET_MV} * {16'h0000, `SFS_PCT_FULL + ov_pct_eff});

    // state qualifiers
    assign active     = (state_ff == ST_DELAY) || (state_ff == ST_RAMP)
                        || (state_ff == ST_TRIM) || (state_ff == ST_RUN);
    assign counting   = (state_ff == ST_DELAY) || (state_ff == ST_RAMP)
                        || (state_ff == ST_TRIM);
    assign dly_done   = (state_ff == ST_DELAY) && (cnt_ff == DLY_LAST);
    assign ramp_done  = cnt_ff == RAMP_LAST;
    assign uv_trip    = uv && (UV_RESP == UV_RESP_RETRY);
    assign uv_give_up = uv && (UV_RESP == UV_RESP_DELAYED) && (uv_dly_ff == UV_LAST);
    assign run_fault  = !en_s2_ff || ov || uv_trip || uv_give_up;
    assign sample_now = dly_done && en_s2_ff && !uv;

    // retry bookkeeping, all-ones means unlimited
    assign uv_retry_ok = (UV_RETRIES == `SFS_RETRY_INF) || (uv_tries_ff < UV_RETRIES);
    assign ov_retry_ok = (OV_RETRIES == `SFS_RETRY_INF) || (ov_tries_ff < OV_RETRIES);
    assign retry_ok    = cause_ov_ff ? ov_retry_ok : uv_retry_ok;
    assign cause_clear = cause_ov_ff ? !ov : !uv;
    assign retry_step  = ((state_ff == ST_SHUT) || (state_ff == ST_CROWBAR))
                         && (nxt_state == ST_DELAY);
    assign ov_dest = ((OV_RESP == OV_RESP_CROWBAR) && !EXT_CLK_MODE)
                     ? ST_CROWBAR : ST_SHUT;

    // sequencing state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (en_s2_ff && !uv) nxt_state = ST_DELAY;
            end
            ST_DELAY: begin
                if (!en_s2_ff || uv) nxt_state = ST_OFF;
                else if (dly_done) nxt_state = ov ? ov_dest : ST_RAMP;
            end
            ST_RAMP, ST_TRIM, ST_RUN: begin
                if (!en_s2_ff) nxt_state = ST_OFF;
                else if (ov) nxt_state = ov_dest;
                else if (uv_trip) nxt_state = ST_SHUT;
                else if (uv_give_up) nxt_state = ST_LATCH;
                else if ((state_ff == ST_RAMP) && ramp_done)
                    nxt_state = above_ff ? ST_TRIM : ST_RUN;
                else if ((state_ff == ST_TRIM) && ramp_done) nxt_state = ST_RUN;
            end
            ST_SHUT, ST_CROWBAR: begin
                if (!en_s2_ff) nxt_state = ST_OFF;
                else if (cause_clear) nxt_state = retry_ok ? ST_DELAY : ST_LATCH;
            end
            ST_LATCH: begin
                if (!en_s2_ff || RESTART) nxt_state = ST_OFF;
            end
            default: nxt_state = ST_OFF;
        endcase
    end

    assign nxt_cnt = ((nxt_state != state_ff) || !counting) ? '0 : cnt_ff + 1'b1;

    // pre-bias sample taken as the turn-on delay expires
    assign nxt_pb    = sample_now ? VSENSE_MV : pb_ff;
    assign nxt_above = sample_now ? (VSENSE_MV > TARGET_MV) : above_ff;

    // reference interpolation scaled so every ramp takes the same time
    assign ramp_diff = nxt_above ? nxt_pb - TARGET_MV : TARGET_MV - nxt_pb;
    assign ramp_prod = {{CNT_W{1'b0}}, ramp_diff} * {{`SFS_MV_W{1'b0}}, nxt_cnt};
    assign ramp_frac = `SFS_MV_W'(ramp_prod / PW'(RAMP_CYCLES));
    assign nxt_ref = (nxt_state == ST_RAMP) ? (nxt_above ? nxt_pb
                                                         : nxt_pb + ramp_frac) :
                     (nxt_state == ST_TRIM) ? nxt_pb - ramp_frac :
                     (nxt_state == ST_RUN)  ? TARGET_MV : '0;

    // driver and power-good decode, overvoltage pulls power-good at once
    assign nxt_hs = (nxt_state == ST_RAMP) || (nxt_state == ST_TRIM) || (nxt_state == ST_RUN);
    assign nxt_ls = nxt_hs || (nxt_state == ST_CROWBAR);
    assign nxt_pg = ((nxt_state == ST_RUN) || (nxt_state == ST_TRIM)) && !ov;

    // state, counters and captured values
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_ff <= ST_OFF;
            cnt_ff   <= '0;
            pb_ff    <= '0;
            above_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            pb_ff    <= nxt_pb;
            above_ff <= nxt_above;
        end
    end

    // undervoltage persistence timer for the delayed response
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            uv_dly_ff <= '0;
        end else if (active && uv && (UV_RESP == UV_RESP_DELAYED) && !uv_give_up) begin
            uv_dly_ff <= uv_dly_ff + 1'b1;
        end else begin
            uv_dly_ff <= '0;
        end
    end

    // retry counters per fault type, cleared while in ST_OFF
    always_ff @(posedge CLK) begin
        if (!RESET_N || (state_ff == ST_OFF)) begin
            uv_tries_ff <= '0;
            ov_tries_ff <= '0;
            cause_ov_ff <= 1'b0;
        end else begin
            if (retry_step && !cause_ov_ff) uv_tries_ff <= uv_tries_ff + 1'b1;
            if (retry_step && cause_ov_ff) ov_tries_ff <= ov_tries_ff + 1'b1;
            if (active && ((nxt_state == ST_SHUT) || (nxt_state == ST_CROWBAR)))
                cause_ov_ff <= ov;
        end
    end

    // registered outputs; a new fault event beats a clear
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            POWER_GOOD     <= 1'b0;
            HS_EN          <= 1'b0;
            LS_EN          <= 1'b0;
            REF_MV         <= '0;
            LOCKOUT_THR_MV <= `SFS_THR_OPEN_MV;
            UV_FLAG        <= 1'b0;
            OV_FLAG        <= 1'b0;
        end else begin
            POWER_GOOD     <= nxt_pg;
            HS_EN          <= nxt_hs;
            LS_EN          <= nxt_ls;
            REF_MV         <= nxt_ref;
            LOCKOUT_THR_MV <= thr_eff;
            UV_FLAG        <= (active && uv) || (UV_FLAG && !FLAG_CLR);
            OV_FLAG        <= (active && ov) || (OV_FLAG && !FLAG_CLR);
        end
    end

    a_lockout_holds_off: assert property (
        (state_ff == ST_OFF) && uv |=> (state_ff == ST_OFF) && !HS_EN && !LS_EN)
        else $error("output started below the lockout threshold");

    a_host_thr_wins: assert property (
        HOST_THR_VALID && (HOST_THR_MV >= `SFS_THR_MIN_MV) && (HOST_THR_MV <= `SFS_THR_MAX_MV)
        |=> (LOCKOUT_THR_MV == $past(HOST_THR_MV)))
        else $error("host threshold not applied");

    a_ov_drops_pg: assert property (
        ov |=> !POWER_GOOD)
        else $error("power-good stayed high during overvoltage");

    a_crowbar_drive: assert property (
        (state_ff == ST_CROWBAR) |-> !HS_EN && LS_EN && !POWER_GOOD)
        else $error("crowbar drive pattern wrong");

    a_extclk_no_crowbar: assert property (
        (state_ff != ST_CROWBAR) ##1 (state_ff == ST_CROWBAR) |-> !$past(EXT_CLK_MODE))
        else $error("crowbar entered under external clock");

    a_prebias_start: assert property (
        $rose(state_ff == ST_RAMP) |-> (REF_MV == pb_ff) && HS_EN && LS_EN && !POWER_GOOD)
        else $error("ramp did not start from the pre-bias level");

    a_ramp_end_pg: assert property (
        (state_ff == ST_RAMP) && ramp_done && !above_ff && !run_fault
        |=> POWER_GOOD && (REF_MV == $past(TARGET_MV)))
        else $error("ramp did not end at target after ramp time");

    a_prebias_ov_fault: assert property (
        sample_now && ov |=> (state_ff == ST_SHUT) || (state_ff == ST_CROWBAR))
        else $error("turn-on began above the overvoltage limit");

    a_retry_exhaust: assert property (
        (state_ff == ST_SHUT) && en_s2_ff && cause_clear && !retry_ok
        |=> (state_ff == ST_LATCH) [*2])
        else $error("output restarted after retries were used up");

    a_uv_flag_sticky: assert property (
        active && uv |=> UV_FLAG ##1 (UV_FLAG || $past(FLAG_CLR)))
        else $error("undervoltage flag lost");
endmodule
`default_nettype wire

// *** sfs_consts.svh ***
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

// data widths
`define SFS_MV_W          16
`define SFS_RES_IDX_W     5
`define SFS_RETRY_W       3
`define SFS_PCT_W         7

// clock rate and timing figures in their own units
`define SFS_CLK_MHZ       32'hFA
`define SFS_US_PER_MS     32'h3E8
`define SFS_ON_DELAY_US   32'h5
`define SFS_RAMP_MS       32'h5
`define SFS_UV_DELAY_US   32'h64

// lockout threshold range and tri-level strap values, millivolts
`define SFS_THR_MIN_MV    16'h0B22
`define SFS_THR_MAX_MV    16'h3E80
`define SFS_THR_LOW_MV    16'h0BB8
`define SFS_THR_OPEN_MV   16'h1194
`define SFS_THR_HIGH_MV   16'h2A30

// overvoltage margin and retry encoding
`define SFS_OV_PCT_DEF    7'h0F
`define SFS_PCT_FULL      8'h64
`define SFS_RETRY_INF     3'h7

`endif

// *** sfs_pkg.sv ***
`default_nettype none
package sfs_pkg;
    typedef enum logic [2:0] {
        ST_OFF     = 3'h0,
        ST_DELAY   = 3'h1,
        ST_RAMP    = 3'h3,
        ST_RUN     = 3'h2,
        ST_TRIM    = 3'h6,
        ST_SHUT    = 3'h7,
        ST_CROWBAR = 3'h5,
        ST_LATCH   = 3'h4
    } sfs_state_t;
    typedef enum logic [1:0] {
        UV_RESP_RETRY    = 2'h0,
        UV_RESP_CONTINUE = 2'h1,
        UV_RESP_DELAYED  = 2'h2
    } sfs_uv_resp_t;
    typedef enum logic {
        OV_RESP_RETRY   = 1'h0,
        OV_RESP_CROWBAR = 1'h1
    } sfs_ov_resp_t;
    typedef enum logic [1:0] {
        STRAP_LOW  = 2'h0,
        STRAP_OPEN = 2'h1,
        STRAP_HIGH = 2'h2,
        STRAP_RES  = 2'h3
    } sfs_strap_t;
endpackage
`default_nettype wire

// *** sfs_strap_decode.sv ***
`default_nettype none
`include "sfs_consts.svh"
module sfs_strap_decode (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire sfs_pkg::sfs_strap_t        strap_pin,
    input  wire logic [`SFS_RES_IDX_W-1:0]  res_idx_pin,
    output logic [`SFS_MV_W-1:0]            thr_mv
);
    import sfs_pkg::*;

    sfs_strap_t                 strap_s1_ff;
    sfs_strap_t                 strap_s2_ff;
    logic [`SFS_RES_IDX_W-1:0]  idx_s1_ff;
    logic [`SFS_RES_IDX_W-1:0]  idx_s2_ff;
    logic [`SFS_MV_W-1:0]       res_mv;
    logic [`SFS_MV_W-1:0]       nxt_thr_mv;

    // two-stage synchroniser for the strap measurement
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strap_s1_ff <= STRAP_OPEN;
            strap_s2_ff <= STRAP_OPEN;
            idx_s1_ff   <= '0;
            idx_s2_ff   <= '0;
        end else begin
            strap_s1_ff <= strap_pin;
            strap_s2_ff <= strap_s1_ff;
            idx_s1_ff   <= res_idx_pin;
            idx_s2_ff   <= idx_s1_ff;
        end
    end

    // resistor lookup, 17.8k at index 0 up to 100k at index 18
    always_comb begin
        case (idx_s2_ff)
            5'h00:   res_mv = 16'h0B22;
            5'h01:   res_mv = 16'h0C44;
            5'h02:   res_mv = 16'h0D70;
            5'h03:   res_mv = 16'h0ECE;
            5'h04:   res_mv = 16'h1054;
            5'h05:   res_mv = 16'h11EE;
            5'h06:   res_mv = 16'h13C4;
            5'h07:   res_mv = 16'h15C2;
            5'h08:   res_mv = 16'h17F2;
            5'h09:   res_mv = 16'h1A5E;
            5'h0A:   res_mv = 16'h1CFC;
            5'h0B:   res_mv = 16'h1FF4;
            5'h0C:   res_mv = 16'h231E;
            5'h0D:   res_mv = 16'h26AC;
            5'h0E:   res_mv = 16'h2A94;
            5'h0F:   res_mv = 16'h2EE0;
            5'h10:   res_mv = 16'h3390;
            5'h11:   res_mv = 16'h38CC;
            5'h12:   res_mv = 16'h3E80;
            default: res_mv = `SFS_THR_OPEN_MV;
        endcase
    end

    // tri-level selection, open falls back to the default
    assign nxt_thr_mv = (strap_s2_ff == STRAP_LOW)  ? `SFS_THR_LOW_MV :
                        (strap_s2_ff == STRAP_HIGH) ? `SFS_THR_HIGH_MV :
                        (strap_s2_ff == STRAP_RES)  ? res_mv :
                                                      `SFS_THR_OPEN_MV;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            thr_mv <= `SFS_THR_OPEN_MV;
        end else begin
            thr_mv <= nxt_thr_mv;
        end
    end

    a_strap_open_default: assert property (@(posedge clk) disable iff (!reset_n)
        (strap_s2_ff == STRAP_OPEN) |=> (thr_mv == `SFS_THR_OPEN_MV))
        else $error("open strap did not give the default threshold");
endmodule
`default_nettype wire

// *** sfs_power_stage.sv ***
`default_nettype none
module sfs_power_stage (
    input  wire logic        hs_en,
    input  wire logic        ls_en,
    input  wire logic [15:0] ref_mv,
    input  wire logic [15:0] pb_mv,
    input  wire logic [15:0] ov_add,
    output logic      [15:0] vsense_mv
);
    timeunit 1ns;
    timeprecision 1ps;
    // output follows the reference while both switches run, else the pre-bias stays
    assign vsense_mv = ((hs_en && ls_en) ? ref_mv : pb_mv) + ov_add;
endmodule
`default_nettype wire

// *** test_sfs_supervisor.sv ***
`default_nettype none
`include "sfs_consts.svh"
module test_sfs_supervisor;
    timeunit 1ns;
    timeprecision 1ps;
    import sfs_pkg::*;
    localparam int RAMP = 16;
    localparam int UVD  = 8;
    logic         CLK = 1'b0, RESET_N = 1'b0, ENABLE = 1'b0, RESTART = 1'b0;
    logic         HOST_THR_VALID = 1'b0, EXT_CLK_MODE = 1'b0, FLAG_CLR = 1'b0;
    sfs_strap_t   STRAP_LEVEL = STRAP_OPEN;
    sfs_uv_resp_t UV_RESP = UV_RESP_RETRY;
    sfs_ov_resp_t OV_RESP = OV_RESP_RETRY;
    logic [4:0]   STRAP_RES_IDX = 5'h00;
    logic [15:0]  HOST_THR_MV = 16'h0000, VIN_MV = 16'h2EE0, TARGET_MV = 16'h03E8;
    logic [15:0]  pb_mv = 16'h0000, ov_add = 16'h0000;
    logic [6:0]   OV_PCT = 7'h00;
    logic [2:0]   UV_RETRIES = 3'h7, OV_RETRIES = 3'h7;
    wire logic    POWER_GOOD, HS_EN, LS_EN, UV_FLAG, OV_FLAG;
    wire logic [15:0] REF_MV, LOCKOUT_THR_MV, VSENSE_MV;
    int           fail_count = 0, num_checks = 0, cycles = 0, n, tgt, lim;
    // expected strap thresholds in millivolts
    logic [15:0]  lvl_mv [3] = '{16'h0BB8, 16'h1194, 16'h2A30};
    logic [15:0]  res_tab [19] = '{16'h0B22, 16'h0C44, 16'h0D70, 16'h0ECE, 16'h1054,
        16'h11EE, 16'h13C4, 16'h15C2, 16'h17F2, 16'h1A5E, 16'h1CFC, 16'h1FF4, 16'h231E,
        16'h26AC, 16'h2A94, 16'h2EE0, 16'h3390, 16'h38CC, 16'h3E80};

    sfs_supervisor #(.ON_DELAY_CYCLES(8), .RAMP_CYCLES(RAMP), .UV_DELAY_CYCLES(UVD)) dut (
        .CLK(CLK), .RESET_N(RESET_N), .ENABLE(ENABLE), .RESTART(RESTART),
        .STRAP_LEVEL(STRAP_LEVEL), .STRAP_RES_IDX(STRAP_RES_IDX),
        .HOST_THR_MV(HOST_THR_MV), .HOST_THR_VALID(HOST_THR_VALID), .VIN_MV(VIN_MV),
        .VSENSE_MV(VSENSE_MV), .TARGET_MV(TARGET_MV), .OV_PCT(OV_PCT), .UV_RESP(UV_RESP),
        .UV_RETRIES(UV_RETRIES), .OV_RESP(OV_RESP), .OV_RETRIES(OV_RETRIES),
        .EXT_CLK_MODE(EXT_CLK_MODE), .FLAG_CLR(FLAG_CLR), .POWER_GOOD(POWER_GOOD),
        .HS_EN(HS_EN), .LS_EN(LS_EN), .REF_MV(REF_MV), .LOCKOUT_THR_MV(LOCKOUT_THR_MV),
        .UV_FLAG(UV_FLAG), .OV_FLAG(OV_FLAG));

    sfs_power_stage stage (.hs_en(HS_EN), .ls_en(LS_EN), .ref_mv(REF_MV), .pb_mv(pb_mv),
        .ov_add(ov_add), .vsense_mv(VSENSE_MV));

    // clock and hang guard
    always #2 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("BAD %0t run did not finish", $time);
            results();
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // waits for drivers (pg=0) or power-good (pg=1), bounded
    task automatic wait_for(input bit pg);
        n = 0;
        while ((pg ? POWER_GOOD : HS_EN) !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk(16'(n < 200), 16'h0001);
    endtask

    task automatic start();
        ENABLE = 1'b1;
        wait_for(1'b0);
        chk(REF_MV, pb_mv);
        wait_for(1'b1);
        chk(16'(n), 16'(RAMP));
    endtask

    // drops the enable and clears the sticky flags while the output winds down
    task automatic stop();
        ENABLE = 1'b0;
        FLAG_CLR = 1'b1;
        tick(1);
        FLAG_CLR = 1'b0;
        tick(3);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h421dd97b));
        tick(2);
        chk(LOCKOUT_THR_MV, 16'h1194);
        chk({13'h0000, POWER_GOOD, HS_EN, LS_EN}, 16'h0000);
        tick(1);
        RESET_N = 1'b1;
        // tri-level strap, then every resistor entry
        for (int i = 0; i < 3; i++) begin
            STRAP_LEVEL = sfs_strap_t'(i);
            tick(6);
            chk(LOCKOUT_THR_MV, lvl_mv[i]);
        end
        STRAP_LEVEL = STRAP_RES;
        for (int i = 0; i < 19; i++) begin
            STRAP_RES_IDX = 5'(i);
            tick(6);
            chk(LOCKOUT_THR_MV, res_tab[i]);
        end
        // host value in range, then both edges just out of range
        HOST_THR_VALID = 1'b1;
        for (int i = 0; i < 3; i++) begin
            HOST_THR_MV = (i == 0) ? 16'($urandom_range(2850, 16000)) :
                          (i == 1) ? 16'h0B21 : 16'h3E81;
            tick(3);
            chk(LOCKOUT_THR_MV, (i == 0) ? HOST_THR_MV : res_tab[18]);
        end
        HOST_THR_VALID = 1'b0;
        STRAP_LEVEL = STRAP_OPEN;
        tick(6);
        // start refused under lockout
        VIN_MV = 16'h0FA0;
        ENABLE = 1'b1;
        tick(30);
        chk({15'h0000, HS_EN}, 16'h0000);
        tgt = 20 * $urandom_range(40, 150);
        lim = tgt * 115 / 100;
        TARGET_MV = 16'(tgt);
        pb_mv = 16'(tgt / 3);
        VIN_MV = 16'h2EE0;
        start();
        chk(REF_MV, TARGET_MV);
        // overvoltage boundary, shutdown, automatic restart, flag clear
        ov_add = 16'(lim - tgt);
        tick(4);
        chk({15'h0000, POWER_GOOD}, 16'h0001);
        ov_add = ov_add + 16'h0001;
        tick(1);
        chk({13'h0000, POWER_GOOD, HS_EN, LS_EN}, 16'h0000);
        tick(1);
        chk({15'h0000, OV_FLAG}, 16'h0001);
        ov_add = 16'h0000;
        wait_for(1'b1);
        FLAG_CLR = 1'b1;
        tick(1);
        FLAG_CLR = 1'b0;
        tick(1);
        chk({15'h0000, OV_FLAG}, 16'h0000);
        // crowbar, and crowbar replaced under external clock
        OV_RESP = OV_RESP_CROWBAR;
        for (int m = 1; m < 3; m++) begin
            EXT_CLK_MODE = (m == 2);
            ov_add = 16'(tgt);
            tick(1);
            chk({13'h0000, POWER_GOOD, HS_EN, LS_EN}, 16'(m == 1));
            tick(20);
            chk({15'h0000, LS_EN}, 16'(m == 1));
            ov_add = 16'h0000;
            wait_for(1'b1);
        end
        OV_RESP = OV_RESP_RETRY;
        EXT_CLK_MODE = 1'b0;
        // undervoltage: shutdown and retry, continue, delayed latch-off
        for (int r = 0; r < 3; r++) begin
            UV_RESP = sfs_uv_resp_t'(r);
            FLAG_CLR = 1'b1;
            tick(1);
            FLAG_CLR = 1'b0;
            VIN_MV = 16'h0FA0;
            tick(UVD - 2);
            chk({15'h0000, HS_EN}, 16'(r != 0));
            tick(6);
            chk({14'h0000, HS_EN, UV_FLAG}, {14'h0000, r == 1, 1'b1});
            VIN_MV = 16'h2EE0;
            tick(30);
            chk({15'h0000, HS_EN}, 16'(r != 2));
            if (r == 2) begin
                RESTART = 1'b1;
                tick(1);
                RESTART = 1'b0;
            end
            wait_for(1'b1);
        end
        UV_RESP = UV_RESP_RETRY;
        // pre-bias above target under a wider 30 percent margin, power-good then trim down
        stop();
        OV_PCT = 7'h1E;
        pb_mv = 16'(tgt + tgt / 5);
        start();
        tick(RAMP + 2);
        chk(REF_MV, TARGET_MV);
        OV_PCT = 7'h00;
        // pre-bias above the limit blocks the start
        stop();
        pb_mv = 16'(lim + 10);
        ENABLE = 1'b1;
        tick(40);
        chk({13'h0000, HS_EN, LS_EN, OV_FLAG}, 16'h0001);
        // no retries left keeps the output off
        stop();
        pb_mv = 16'h0000;
        OV_RETRIES = 3'h0;
        start();
        ov_add = 16'(tgt);
        tick(2);
        ov_add = 16'h0000;
        tick(40);
        chk({15'h0000, HS_EN}, 16'h0000);
        stop();
        start();
        results();
    end
endmodule
`default_nettype wire
